// file: hdl/sfp_map.svh
// Purpose: Opcodes, status layout, reset value and timing of the flash
//          command front end.
// Assumes: A 40 MHz system clock.
// Notes:   Definitions only.
`ifndef SFP_MAP_SVH
`define SFP_MAP_SVH

`define SFP_OP_RDSR 8'h05
`define SFP_OP_STATUS_WRITE_CMD 8'h01
`define SFP_OP_WRITE_ENABLE_CMD 8'h06
`define SFP_OP_WRITE_DISABLE_CMD 8'h04
`define SFP_OP_BYTE 8'h02
`define SFP_OP_AAI 8'hAD
`define SFP_OP_SECT 8'h20
`define SFP_OP_BLK 8'hD8
`define SFP_OP_CHIP_A 8'h60
`define SFP_OP_CHIP_B 8'hC7

`define SFP_ST_BUSY 0
`define SFP_ST_WEL 1
`define SFP_ST_BP_LO 2
`define SFP_ST_BP_HI 4
`define SFP_ST_RSVD 5
`define SFP_ST_AAI 6
`define SFP_ST_LOCK 7
`define SFP_ST_RESET 8'h1C

`define SFP_ADDR_TOP 19'h7FFFF
`define SFP_CLK_NS 25
`define SFP_T_PROG_NS 9000
`define SFP_PROG_CYC (`SFP_T_PROG_NS / `SFP_CLK_NS)
`define SFP_T_SECT_MS 60
`define SFP_T_BLK_MS 1000
`define SFP_T_CHIP_MS 4000
`define SFP_MS_CYC(ms) ((ms) * (1000000 / `SFP_CLK_NS))

`endif

// file: hdl/sfp_pkg.sv
// Purpose: Types shared by the flash command front end.
// Assumes: Nothing beyond the map header.
// Notes:   Kinds of internal write operation that keep the device busy.
package sfp_pkg;
    typedef enum logic [2:0] {
        SFP_OP_NONE = 3'b000,
        SFP_OP_PROG = 3'b001,
        SFP_OP_AAI = 3'b010,
        SFP_OP_ERASE = 3'b011
    } sfp_op_e;
endpackage

// file: hdl/sfp_sync.sv
// Purpose: Two flip-flop synchroniser for a bundle of levels.
// Assumes: Each bit is a level that holds for several destination clocks.
// Notes:   The first stage is read by the second stage only.
`timescale 1ns/1ps
module sfp_sync #(
    parameter int W = 1
) (
    // Clock
    input wire logic clk_i,
    // Data
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge clk_i) begin
        meta_q <= d_i;
        sync_q <= meta_q;
    end

    assign q_o = sync_q;
endmodule

// file: hdl/sfp_core.sv
// Purpose: Serial command front end of a byte-serial flash: framing, pause,
//          status register and write protection.
// Assumes: sck_i is the host serial clock; clk_sys_i runs at 40 MHz.
// Notes:   The array itself is absent; busy lasts a timed interval.
`timescale 1ns/1ps
`include "sfp_map.svh"
module sfp_core #(
    parameter int PROG_CYC = `SFP_PROG_CYC,
    parameter int SECT_CYC = `SFP_MS_CYC(`SFP_T_SECT_MS),
    parameter int BLK_CYC = `SFP_MS_CYC(`SFP_T_BLK_MS),
    parameter int CHIP_CYC = `SFP_MS_CYC(`SFP_T_CHIP_MS)
) (
    // System clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Serial link
    input wire logic sck_i,
    input wire logic select_n_i,
    input wire logic si_i,
    input wire logic pause_n_i,
    input wire logic protect_n_i,
    output logic so_o,
    output logic so_oe_o,
    // Status view
    output logic [7:0] status_o
);
    // Link side, frame state: cleared whenever select is high.
    logic [2:0] bit_q, bit_d;
    logic [2:0] byte_q, byte_d;
    logic [7:0] sh_q, sh_d;
    logic [7:0] op_q, op_d;
    logic [23:0] adr_q, adr_d;
    logic rd_q, rd_d;
    // Link side, command hand-off: survives the end of the frame.
    logic tog_q, tog_d;
    logic [7:0] ev_op_q, ev_op_d;
    logic [7:0] ev_dat_q, ev_dat_d;
    logic [18:0] ev_adr_q, ev_adr_d;
    // Link side, output shifter.
    logic so_q, so_d;
    logic [7:0] osh_q, osh_d;
    logic [7:0] st_lk;
    logic [7:0] byte_in;
    logic byte_end;

    assign byte_in = {sh_q[6:0], si_i};
    assign byte_end = pause_n_i && bit_q == 3'h7;

    always_comb begin
        bit_d = bit_q;
        byte_d = byte_q;
        sh_d = sh_q;
        op_d = op_q;
        adr_d = adr_q;
        rd_d = rd_q;
        tog_d = tog_q;
        ev_op_d = ev_op_q;
        ev_dat_d = ev_dat_q;
        ev_adr_d = ev_adr_q;
        // Pause low at a rising edge means the clock edge is ignored.
        if (pause_n_i) begin
            sh_d = byte_in;
            bit_d = bit_q + 3'h1;
        end
        if (byte_end) begin
            if (byte_q != 3'h7) begin
                byte_d = byte_q + 3'h1;
            end
            if (byte_q == 3'h0) begin
                op_d = byte_in;
                rd_d = byte_in == `SFP_OP_RDSR;
                if (byte_in == `SFP_OP_WRITE_ENABLE_CMD || byte_in == `SFP_OP_WRITE_DISABLE_CMD ||
                    byte_in == `SFP_OP_CHIP_A ||
                    byte_in == `SFP_OP_CHIP_B) begin
                    tog_d = ~tog_q;
                    ev_op_d = byte_in;
                end
            end else if (byte_q <= 3'h3) begin
                adr_d = {adr_q[15:0], byte_in};
            end
            if (byte_q == 3'h1 && op_q == `SFP_OP_STATUS_WRITE_CMD) begin
                tog_d = ~tog_q;
                ev_op_d = op_q;
                ev_dat_d = byte_in;
            end
            if (byte_q == 3'h3 &&
                (op_q == `SFP_OP_SECT || op_q == `SFP_OP_BLK)) begin
                tog_d = ~tog_q;
                ev_op_d = op_q;
                ev_adr_d = {adr_q[10:0], byte_in};
            end
            if (byte_q == 3'h4 &&
                (op_q == `SFP_OP_BYTE || op_q == `SFP_OP_AAI)) begin
                tog_d = ~tog_q;
                ev_op_d = op_q;
                ev_dat_d = byte_in;
                ev_adr_d = adr_q[18:0];
            end
        end
    end

    // A partial bus cycle never reaches the hand-off, so it just vanishes.
    always_ff @(posedge sck_i or posedge select_n_i or posedge rst_i) begin
        if (rst_i || select_n_i) begin
            bit_q <= 3'h0;
            byte_q <= 3'h0;
            sh_q <= 8'h00;
            op_q <= 8'h00;
            adr_q <= 24'h000000;
            rd_q <= 1'b0;
        end else begin
            bit_q <= bit_d;
            byte_q <= byte_d;
            sh_q <= sh_d;
            op_q <= op_d;
            adr_q <= adr_d;
            rd_q <= rd_d;
        end
    end

    always_ff @(posedge sck_i or posedge rst_i) begin
        if (rst_i) begin
            tog_q <= 1'b0;
            ev_op_q <= 8'h00;
            ev_dat_q <= 8'h00;
            ev_adr_q <= 19'h00000;
        end else begin
            tog_q <= tog_d;
            ev_op_q <= ev_op_d;
            ev_dat_q <= ev_dat_d;
            ev_adr_q <= ev_adr_d;
        end
    end

    // Status shifts out MSB first and repeats for as long as select holds.
    always_comb begin
        so_d = so_q;
        osh_d = osh_q;
        if (pause_n_i && rd_q) begin
            if (bit_q == 3'h0) begin
                so_d = st_lk[7];
                osh_d = {st_lk[6:0], 1'b0};
            end else begin
                so_d = osh_q[7];
                osh_d = {osh_q[6:0], 1'b0};
            end
        end
    end

    // Falling-edge launch suits both idle levels of the serial clock.
    always_ff @(negedge sck_i or posedge select_n_i or posedge rst_i) begin
        if (rst_i || select_n_i) begin
            so_q <= 1'b0;
            osh_q <= 8'h00;
        end else begin
            so_q <= so_d;
            osh_q <= osh_d;
        end
    end

    assign so_o = so_q;

    // System side.
    logic [7:0] status_q, status_d;
    logic hold_q, hold_d;
    logic oe_q, oe_d;
    logic seen_q, seen_d;
    logic [31:0] cnt_q, cnt_d;
    logic [18:0] aadr_q, aadr_d;
    sfp_pkg::sfp_op_e kind_q, kind_d;
    logic [5:0] pin_s;
    logic sck_s, sel_n_s, pause_n_s, prot_n_s, rd_s, tog_s;
    logic fire, locked, guarded, is_pgm;
    logic [2:0] bp;

    sfp_sync #(.W(6)) u_sync_sys (
        .clk_i(clk_sys_i),
        .d_i({sck_i, select_n_i, pause_n_i, protect_n_i, rd_q, tog_q}),
        .q_o(pin_s)
    );

    sfp_sync #(.W(8)) u_sync_link (
        .clk_i(sck_i),
        .d_i(status_q),
        .q_o(st_lk)
    );

    assign {sck_s, sel_n_s, pause_n_s, prot_n_s, rd_s, tog_s} = pin_s;
    assign fire = tog_s != seen_q;
    assign bp = status_q[`SFP_ST_BP_HI:`SFP_ST_BP_LO];
    assign locked = status_q[`SFP_ST_LOCK] && !prot_n_s;
    assign is_pgm = ev_op_q == `SFP_OP_BYTE || ev_op_q == `SFP_OP_AAI ||
        ev_op_q == `SFP_OP_SECT || ev_op_q == `SFP_OP_BLK;

    always_comb begin
        unique case (bp)
            3'b000: guarded = 1'b0;
            3'b001: guarded = ev_adr_q[18:16] == 3'b111;
            3'b010: guarded = ev_adr_q[18:17] == 2'b11;
            3'b011: guarded = ev_adr_q[18];
            default: guarded = 1'b1;
        endcase
    end

    always_comb begin
        status_d = status_q;
        kind_d = kind_q;
        cnt_d = cnt_q;
        aadr_d = aadr_q;
        seen_d = tog_s;
        // Pause level follows the pin only while the clock sits low.
        hold_d = hold_q;
        if (!sck_s) begin
            hold_d = !pause_n_s && (hold_q || !sel_n_s);
        end
        oe_d = rd_s && !sel_n_s && !hold_d;
        if (status_q[`SFP_ST_BUSY]) begin
            cnt_d = cnt_q - 32'h1;
            if (cnt_q <= 32'h1) begin
                status_d[`SFP_ST_BUSY] = 1'b0;
                if (kind_q != sfp_pkg::SFP_OP_AAI ||
                    aadr_q == `SFP_ADDR_TOP) begin
                    status_d[`SFP_ST_WEL] = 1'b0;
                    status_d[`SFP_ST_AAI] = 1'b0;
                end
                if (kind_q == sfp_pkg::SFP_OP_AAI) begin
                    aadr_d = aadr_q + 19'h1;
                end
                kind_d = sfp_pkg::SFP_OP_NONE;
            end
        end else if (fire) begin
            if (ev_op_q == `SFP_OP_WRITE_ENABLE_CMD) begin
                status_d[`SFP_ST_WEL] = 1'b1;
            end
            if (ev_op_q == `SFP_OP_WRITE_DISABLE_CMD) begin
                status_d[`SFP_ST_WEL] = 1'b0;
                status_d[`SFP_ST_AAI] = 1'b0;
            end
            if (ev_op_q == `SFP_OP_STATUS_WRITE_CMD) begin
                status_d[`SFP_ST_WEL] = 1'b0;
                if (!locked) begin
                    status_d[`SFP_ST_BP_HI:`SFP_ST_BP_LO] = ev_dat_q[4:2];
                    status_d[`SFP_ST_LOCK] = ev_dat_q[7];
                end
            end
            if (status_q[`SFP_ST_WEL] && is_pgm && !guarded) begin
                status_d[`SFP_ST_BUSY] = 1'b1;
                kind_d = sfp_pkg::SFP_OP_ERASE;
                cnt_d = ev_op_q == `SFP_OP_SECT ? SECT_CYC : BLK_CYC;
                if (ev_op_q == `SFP_OP_BYTE) begin
                    kind_d = sfp_pkg::SFP_OP_PROG;
                    cnt_d = PROG_CYC;
                end
                if (ev_op_q == `SFP_OP_AAI) begin
                    kind_d = sfp_pkg::SFP_OP_AAI;
                    cnt_d = PROG_CYC;
                    status_d[`SFP_ST_AAI] = 1'b1;
                    if (!status_q[`SFP_ST_AAI]) begin
                        aadr_d = ev_adr_q;
                    end
                end
            end
            if (status_q[`SFP_ST_WEL] && bp == 3'b000 &&
                (ev_op_q == `SFP_OP_CHIP_A ||
                ev_op_q == `SFP_OP_CHIP_B)) begin
                status_d[`SFP_ST_BUSY] = 1'b1;
                kind_d = sfp_pkg::SFP_OP_ERASE;
                cnt_d = CHIP_CYC;
            end
        end
        status_d[`SFP_ST_RSVD] = 1'b0;
    end

    // Synchronous reset keeps the seen copy equal to the live toggle so a
    // stale link toggle cannot fire a command after reset.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            status_q <= `SFP_ST_RESET;
            kind_q <= sfp_pkg::SFP_OP_NONE;
            cnt_q <= 32'h0;
            aadr_q <= 19'h00000;
            hold_q <= 1'b0;
            oe_q <= 1'b0;
            seen_q <= 1'b0;
        end else begin
            status_q <= status_d;
            kind_q <= kind_d;
            cnt_q <= cnt_d;
            aadr_q <= aadr_d;
            hold_q <= hold_d;
            oe_q <= oe_d;
            seen_q <= seen_d;
        end
    end

    assign so_oe_o = oe_q;
    assign status_o = status_q;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    a_reset_value: assert property ($past(rst_i) |-> status_q == 8'h1C)
        else $error("status not at power-up value");
    a_rsvd_zero: assert property (!status_q[5])
        else $error("reserved status bit set");
    a_wsr_locked: assert property (fire && !status_q[0] &&
        ev_op_q == 8'h01 && locked |=> $stable(status_q[7:2]))
        else $error("locked status write took effect");
    a_wsr_wel: assert property (fire && !status_q[0] &&
        ev_op_q == 8'h01 |=> !status_q[1] && $stable(status_q[6]))
        else $error("status write left latch or changed auto bit");
    a_wel_gate: assert property (fire && !status_q[0] &&
        !status_q[1] |=> !status_q[0])
        else $error("write started without latch");
    a_chip_guard: assert property (fire && !status_q[0] &&
        ev_op_q == 8'h60 && bp != 3'b000 |=> !status_q[0])
        else $error("chip erase ran while protected");
    a_busy_end: assert property ($fell(status_q[0]) &&
        $past(kind_q) != sfp_pkg::SFP_OP_AAI |-> !status_q[1])
        else $error("latch survived write completion");
    a_pause_enter: assert property (!sck_s && !pause_n_s &&
        !sel_n_s ##1 1'b1 |-> hold_q)
        else $error("pause not entered");
    a_pause_oe: assert property (hold_q |-> !so_oe_o)
        else $error("output driven while paused");
    a_pause_leave: assert property (hold_q && !sck_s &&
        pause_n_s |=> !hold_q)
        else $error("pause not left");

    c_wsr: cover property (fire && ev_op_q == 8'h01);
    c_busy: cover property ($rose(status_q[0]));
    c_pause: cover property ($rose(hold_q));
    c_read: cover property ($rose(so_oe_o));
endmodule

// file: bench/sfp_host.sv
// Purpose: Host end of the serial link: frames, status reads and pause.
// Assumes: A 3 ns half period gives the 6 ns link clock.
// Notes:   The link clock stands still between frames and runs only while bits are sent, paused or not.
`timescale 1ns/1ps
module sfp_host (
    // Link outputs
    output logic sck_o,
    output logic select_n_o,
    output logic si_o,
    output logic pause_n_o,
    // Link input
    input wire logic so_i
);
    bit mode3 = 1'b0;

    initial begin
        sck_o = 1'b0;
        select_n_o = 1'b1;
        si_o = 1'b0;
        pause_n_o = 1'b1;
    end

    // Data changes with the falling edge; the reply is taken at the rise.
    task automatic bit_x(input logic b, output logic r);
        sck_o = 1'b0;
        si_o = b;
        #3;
        sck_o = 1'b1;
        r = so_i;
        #3;
    endtask

    task automatic start(input bit m3);
        mode3 = m3;
        sck_o = m3;
        #10;
        select_n_o = 1'b0;
        #10;
    endtask

    task automatic stop();
        if (!mode3)
            sck_o = 1'b0;
        #3;
        select_n_o = 1'b1;
        // A released data line must not keep showing its last level.
        si_o = ~si_o;
        #150;
    endtask

    task automatic send(input logic [39:0] d, input int nbits);
        logic r;
        for (int i = 0; i < nbits; i++)
            bit_x(d[39 - i], r);
    endtask

    task automatic lo();
        sck_o = 1'b0;
        #200;
    endtask

    task automatic hold(input logic lvl);
        pause_n_o = lvl;
        #200;
    endtask

    task automatic frame(input logic [39:0] d, input int nbits, input bit m3);
        start(m3);
        send(d, nbits);
        stop();
    endtask

    // Slow gap after the opcode lets the output enable come up in time.
    task automatic read_status(input bit m3, output logic [7:0] v);
        logic r;
        start(m3);
        send({8'h05, 32'h0}, 8);
        lo();
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b0, r);
            v[i] = r;
        end
        stop();
    endtask
endmodule

// file: bench/sfp_core_bench.sv
// Purpose: Self-checking bench of the flash command front end.
// Assumes: Shortened busy counts so erase and program finish quickly.
// Notes:   Link traffic comes from the host model; protect from here.
`timescale 1ns/1ps
module sfp_core_bench;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic protect_n_i = 1'b1;
    logic sck, select_n, si, pause_n, so_o, so_oe_o, so_w;
    logic [7:0] status_o;
    logic [7:0] exp_st, rd;
    int errors = 0;
    int checks = 0;
    logic [39:0] ops [5] = '{{8'h02, 24'h012345, 8'hA5},
        {8'h20, 32'h00100000}, {8'hD8, 32'h01000000},
        {8'h60, 32'h0}, {8'hC7, 32'h0}};
    int lens [5] = '{40, 32, 32, 8, 8};

    always #12.5 clk_sys_i = ~clk_sys_i;

    // An undriven output line toggles, so a stale bit never matches.
    assign so_w = so_oe_o ? so_o : sck;

    sfp_core #(.PROG_CYC(40), .SECT_CYC(60), .BLK_CYC(60), .CHIP_CYC(60))
    dut (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .sck_i(sck),
        .select_n_i(select_n),
        .si_i(si),
        .pause_n_i(pause_n),
        .protect_n_i(protect_n_i),
        .so_o(so_o),
        .so_oe_o(so_oe_o),
        .status_o(status_o)
    );

    sfp_host host (
        .sck_o(sck),
        .select_n_o(select_n),
        .si_o(si),
        .pause_n_o(pause_n),
        .so_i(so_w)
    );

    function automatic logic [7:0] status_write_cmd(input logic [7:0] cur, d,
                                        input logic wp_n);
        if (!wp_n && cur[7])
            return cur & 8'hFD;
        return {d[7], cur[6], 1'b0, d[4:2], 1'b0, cur[0]};
    endfunction

    task automatic chk(input logic [7:0] got, exp, input string what);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what,
                     got, exp);
        end
    endtask

    task automatic cmd(input logic [39:0] d, input int nbits);
        host.frame(d, nbits, 1'($urandom));
        repeat (4) @(negedge clk_sys_i);
    endtask

    task automatic sw(input logic [7:0] d, input logic wp_n);
        @(negedge clk_sys_i);
        protect_n_i = wp_n;
        cmd({8'h01, d, 24'h0}, 16);
        exp_st = status_write_cmd(exp_st, d, wp_n);
        chk(status_o, exp_st, "status write");
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while (status_o[0] !== 1'b0 && n < 400) begin
            @(negedge clk_sys_i);
            n++;
        end
        chk({7'h0, status_o[0]}, 8'h00, "busy ends");
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        #400000;
        errors++;
        conclude();
    end

    initial begin
        void'($urandom(32'h981E6AD8));
        repeat (5) @(negedge clk_sys_i);
        rst_i = 1'b0;
        repeat (4) @(negedge clk_sys_i);
        exp_st = 8'h1C;
        chk(status_o, exp_st, "reset value");
        chk({7'h0, so_oe_o}, 8'h00, "idle output off");
        $display("test reset done");
        host.frame({8'h06, 32'h0}, 5, 1'($urandom));
        chk(status_o, 8'h1C, "short byte aborted");
        host.start(1'($urandom));
        host.send({8'h06, 32'h0}, 3);
        host.lo();
        host.hold(1'b0);
        host.stop();
        host.hold(1'b1);
        cmd({8'h06, 32'h0}, 8);
        chk(status_o, 8'h1E, "select high resets frame");
        cmd({8'h04, 32'h0}, 8);
        chk(status_o, 8'h1C, "write disable");
        host.frame({8'h06, 32'h0}, 8, 1'b1);
        chk(status_o, 8'h1E, "idle high clock");
        cmd({8'h04, 32'h0}, 8);
        host.start(1'($urandom));
        host.send({8'h06, 32'h0}, 4);
        host.hold(1'b0);
        host.lo();
        chk({7'h0, so_oe_o}, 8'h00, "paused");
        host.send({$urandom, 8'h0}, 3);
        host.hold(1'b1);
        host.lo();
        host.send({4'h6, 36'h0}, 4);
        host.stop();
        chk(status_o, 8'h1E, "edges ignored while paused");
        $display("test framing and pause done");
        exp_st = 8'h1E;
        sw(8'hFF, 1'b1);
        sw(8'h00, 1'b0);
        for (int i = 0; i < 16; i++) begin
            if ($urandom % 4 == 0) begin
                cmd({8'h30 + 8'($urandom % 16), 32'h0}, 8);
                chk(status_o, exp_st, "unknown opcode");
            end else begin
                sw(8'($urandom), 1'($urandom));
            end
        end
        host.read_status(1'($urandom), rd);
        chk(rd, exp_st, "status read");
        host.start(1'($urandom));
        host.send({8'h05, 32'h0}, 8);
        host.lo();
        chk({7'h0, so_oe_o}, 8'h01, "read drives output");
        host.hold(1'b0);
        chk({7'h0, so_oe_o}, 8'h00, "pause releases output");
        host.hold(1'b1);
        host.stop();
        sw(8'h00, 1'b1);
        $display("test status register done");
        foreach (ops[i]) begin
            cmd(ops[i], lens[i]);
            chk(status_o, 8'h00, "ignored without latch");
            cmd({8'h06, 32'h0}, 8);
            cmd(ops[i], lens[i]);
            host.read_status(1'($urandom), rd);
            chk(rd, 8'h03, "busy while writing");
            wait_idle();
            chk(status_o, 8'h00, "completion clears latch");
        end
        exp_st = 8'h00;
        sw(8'h04, 1'b1);
        cmd({8'h06, 32'h0}, 8);
        cmd({8'h60, 32'h0}, 8);
        chk(status_o, 8'h06, "chip erase refused");
        cmd({8'h02, 24'h070000, 8'h5A}, 40);
        chk(status_o, 8'h06, "top eighth protected");
        cmd({8'h02, 24'h06FFFF, 8'h5A}, 40);
        wait_idle();
        chk(status_o, 8'h04, "below top eighth programs");
        // Auto-increment keeps the latch until the top address is written.
        sw(8'h00, 1'b1);
        cmd({8'h06, 32'h0}, 8);
        cmd({8'hAD, 24'h000000, 8'h3C}, 40);
        chk(status_o, 8'h43, "auto program busy");
        wait_idle();
        chk(status_o, 8'h42, "auto program keeps latch");
        cmd({8'h04, 32'h0}, 8);
        chk(status_o, 8'h00, "disable leaves auto mode");
        cmd({8'h06, 32'h0}, 8);
        cmd({8'hAD, 24'h07FFFF, 8'h3C}, 40);
        wait_idle();
        chk(status_o, 8'h00, "top address clears latch");
        $display("test program and erase done");
        conclude();
    end
endmodule
